/* File: hw/edmon_top.sv */
// module: external device monitor with apb registers
`timescale 1ns/100ps
// Behaviour
// - three modes: single channel, dual channel, disabled; ctrl selects
// - dual channel is the reset configuration
// - single: reset refused, outputs off unless feedback shows closed
// - single: while outputs on, feedback changes are ignored
// - after outputs turn off, contacts must close within 250 ms
// - aux output only active in single channel configuration
// - dual: inputs disagreeing over 250 ms causes lockout
// - single: aux output follows the safety output state
module edmon_top
    import edmon_pkg::*;
#(
    parameter int WIN_CYC = int'(EDMON_WIN_CYC) // 250 ms in cycles
) (
    input wire logic pclk, // 20 mhz clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire edmon_fb_s fb, // feedback contacts
    input wire logic guard_clear, // sensing field clear, asks outputs on
    output logic [1:0] safety_output_pair, // paired safety outputs
    output logic aux_out, // auxiliary status output
    output logic lockout, // lockout state
    output logic irq // level interrupt
);
    // ****************************************************
    // apb slave
    // ****************************************************
    logic [1:0] cfg_ff;
    logic [EDMON_IRQ_W-1:0] irqs_ff, mask_ff;
    logic on_ff, lock_ff, ready_ff, pend_ff;
    logic [EDMON_CNT_W-1:0] off_cnt_ff, dis_cnt_ff;
    logic acc, wr, rd_ok;
    logic ev_lock, ev_refuse, ev_on, rst_req;
    logic [EDMON_IRQ_W-1:0] ev;

    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign pready = 1'b1; // zero wait states
    assign rd_ok = paddr == EDMON_CTRL_OFF || paddr == EDMON_STAT_OFF ||
                   paddr == EDMON_IRQS_OFF || paddr == EDMON_MASK_OFF;
    assign pslverr = acc & ~rd_ok;
    assign rst_req = wr && paddr == EDMON_CTRL_OFF &&
                     pwdata[EDMON_CTRL_RST_BIT];

    // read mux into a register, valid in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                EDMON_CTRL_OFF: prdata <= {30'h0, cfg_ff};
                EDMON_STAT_OFF: prdata <= {28'h0, fb.fb_b, fb.fb_a,
                                           lock_ff, on_ff};
                EDMON_IRQS_OFF: prdata <= {29'h0, irqs_ff};
                EDMON_MASK_OFF: prdata <= {29'h0, mask_ff};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // configuration register, dual by default
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff <= EDMON_CFG_RESET;
        end else if (wr && paddr == EDMON_CTRL_OFF &&
                     pwdata[1:0] != 2'h3) begin
            cfg_ff <= pwdata[1:0];
        end
    end

    // ****************************************************
    // monitor core
    // ****************************************************
    logic fb_ok, single, dual, win_miss, dis_miss;
    assign single = cfg_ff == EDMON_CFG_SINGLE;
    assign dual = cfg_ff == EDMON_CFG_DUAL;
    // contacts closed in the selected mode
    assign fb_ok = single ? fb.fb_a :
                   dual ? (fb.fb_a & fb.fb_b) : 1'b1;
    assign win_miss = pend_ff && (off_cnt_ff >= EDMON_CNT_W'(WIN_CYC - 1))
                      && !fb_ok;
    assign dis_miss = dual && (fb.fb_a != fb.fb_b) &&
                      (dis_cnt_ff >= EDMON_CNT_W'(WIN_CYC - 1));
    assign ev_lock = !lock_ff && (win_miss || dis_miss);
    // a reset with contacts closed is accepted, also when it clears lockout
    assign ev_refuse = rst_req && !fb_ok;
    assign ev_on = !on_ff && ready_ff && guard_clear && !lock_ff && !pend_ff;

    // armed by a valid reset; refused while contacts open
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_ff <= 1'b0;
        end else if (ev_lock || (on_ff && !guard_clear)) begin
            ready_ff <= 1'b0;
        end else if (rst_req && fb_ok && !pend_ff) begin
            ready_ff <= 1'b1;
        end
    end

    // outputs on; feedback not looked at while on, except a dual channel disagreement lockout
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_ff <= 1'b0;
        end else if (ev_lock || !guard_clear) begin
            on_ff <= 1'b0;
        end else if (ev_on && fb_ok) begin
            on_ff <= 1'b1;
        end
    end

    // closure window after turn-off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_ff <= 1'b0;
            off_cnt_ff <= '0;
        end else if (on_ff && (ev_lock || !guard_clear)) begin
            pend_ff <= 1'b1;
            off_cnt_ff <= '0;
        end else if (pend_ff && (fb_ok || win_miss)) begin
            pend_ff <= 1'b0;
        end else if (pend_ff) begin
            off_cnt_ff <= off_cnt_ff + 1'b1;
        end
    end

    // dual channel disagreement timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dis_cnt_ff <= '0;
        end else if (dual && fb.fb_a != fb.fb_b) begin
            if (!dis_miss) dis_cnt_ff <= dis_cnt_ff + 1'b1;
        end else begin
            dis_cnt_ff <= '0;
        end
    end

    // latched lockout, left only by a reset with contacts closed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_ff <= 1'b0;
        end else if (ev_lock) begin
            lock_ff <= 1'b1;
        end else if (rst_req && lock_ff && fb_ok && !dis_miss) begin
            lock_ff <= 1'b0;
        end
    end

    // outputs, aux only in single mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            safety_output_pair <= 2'h0;
            aux_out <= 1'b0;
        end else begin
            safety_output_pair <= {2{on_ff}};
            aux_out <= single & on_ff;
        end
    end
    assign lockout = lock_ff;

    // ****************************************************
    // interrupts
    // ****************************************************
    assign ev = {ev_on, ev_refuse, ev_lock};
    // sticky status, set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irqs_ff <= '0;
        end else if (wr && paddr == EDMON_IRQS_OFF) begin
            irqs_ff <= (irqs_ff & ~pwdata[EDMON_IRQ_W-1:0]) | ev;
        end else begin
            irqs_ff <= irqs_ff | ev;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_ff <= '0;
        end else if (wr && paddr == EDMON_MASK_OFF) begin
            mask_ff <= pwdata[EDMON_IRQ_W-1:0];
        end
    end
    assign irq = |(irqs_ff & mask_ff);

    // ****************************************************
    // checks
    // ****************************************************
    lock_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        lock_ff |=> safety_output_pair == 2'h0)
        else $error("outputs on during lockout");
    refuse_a: assert property (@(posedge pclk) disable iff (!presetn)
        (single && !on_ff && !fb.fb_a) |=> !on_ff)
        else $error("single mode turned on with open contacts");
    hold_on_a: assert property (@(posedge pclk) disable iff (!presetn)
        (single && on_ff && guard_clear && !ev_lock) |=> on_ff)
        else $error("feedback dropped outputs");
    window_a: assert property (@(posedge pclk) disable iff (!presetn)
        ($fell(on_ff) && !lock_ff) |-> ##[1:10] (pend_ff || lock_ff ||
        fb_ok))
        else $error("closure window not started");
    aux_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
        !single |=> !aux_out)
        else $error("aux active outside single mode");
    aux_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        single |=> aux_out == $past(on_ff))
        else $error("aux not following outputs");
    dual_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
        dis_miss |=> lock_ff)
        else $error("disagreement did not lock");
    cfg_legal_a: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_ff != 2'h3)
        else $error("illegal configuration");
endmodule // edmon_top

/* File: shared/edmon_pkg.sv */
// package: constants and types for the external device monitor
package edmon_pkg;
    // ****************************************************
    // configuration codes
    // ****************************************************
    typedef enum logic [1:0] {
        EDMON_CFG_NONE   = 2'h0,
        EDMON_CFG_SINGLE = 2'h1,
        EDMON_CFG_DUAL   = 2'h2
    } edmon_cfg_e;
    localparam logic [1:0] EDMON_CFG_RESET = 2'h2; // dual channel default

    // ****************************************************
    // register map (byte offsets)
    // ****************************************************
    localparam logic [11:0] EDMON_CTRL_OFF = 12'h000;
    localparam logic [11:0] EDMON_STAT_OFF = 12'h004;
    localparam logic [11:0] EDMON_IRQS_OFF = 12'h008;
    localparam logic [11:0] EDMON_MASK_OFF = 12'h00c;
    // ctrl fields
    localparam int EDMON_CTRL_CFG_LSB = 0;
    localparam int EDMON_CTRL_RUN_BIT = 2;
    localparam int EDMON_CTRL_RST_BIT = 3;
    // irq status bits
    localparam int EDMON_IRQ_LOCK_BIT = 0;
    localparam int EDMON_IRQ_REFUSE_BIT = 1;
    localparam int EDMON_IRQ_ON_BIT = 2;
    localparam int EDMON_IRQ_W = 3;

    // ****************************************************
    // timing
    // ****************************************************
    localparam longint EDMON_CLK_HZ = 20000000;
    localparam longint EDMON_WIN_MS = 250;
    localparam longint EDMON_WIN_CYC = EDMON_WIN_MS * EDMON_CLK_HZ / 1000;
    localparam int EDMON_CNT_W = 23;

    // feedback inputs travel together
    typedef struct packed {
        logic fb_a; // feedback_input_a, high = contacts closed
        logic fb_b; // feedback_input_b
    } edmon_fb_s;
endpackage

/* File: verif/edmon_relay_model.sv */
// relay and contactor monitor contact model for the device monitor
`timescale 1ns/100ps
module edmon_relay_model
    import edmon_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic [1:0] drive, // safety outputs seen at the coils
    input wire logic [7:0] delay, // contact travel time in cycles
    input wire logic stuck, // contact a welded, never closes
    input wire logic split, // contact b opposes contact a
    input wire logic two_ch, // second channel wired
    output edmon_fb_s fb // monitor contacts, high = closed
);
    logic [7:0] cnt_ff;
    logic [1:0] last_ff;
    logic closed;
    // travel timer restarts whenever the coil drive changes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 8'h00;
            last_ff <= 2'h0;
        end else if (drive != last_ff) begin
            cnt_ff <= 8'h00;
            last_ff <= drive;
        end else if (cnt_ff != 8'hff) begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end
    // coils off drop the load, n.c. contacts close after travel
    assign closed = (last_ff == 2'h0) && (cnt_ff >= delay) && !stuck;
    // second channel left open unless wired for two channels
    assign fb = {closed, two_ch & (closed ^ split)};
endmodule // edmon_relay_model

/* File: verif/tb_top.sv */
// self-checking bench for the external device monitor
`timescale 1ns/100ps
module tb_top;
    import edmon_pkg::*;
    localparam int WIN = 20;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic gc = 1'b0;
    logic stuck = 1'b0;
    logic split = 1'b0;
    logic two_ch = 1'b1;
    logic [7:0] delay = 8'h02;
    logic [31:0] prdata, rd;
    logic pready, pslverr, aux, lock, irq, err;
    logic [1:0] sop;
    edmon_fb_s fb;
    int n_mismatch = 0;
    int compares = 0;
    edmon_top #(.WIN_CYC(WIN)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fb(fb), .guard_clear(gc),
        .safety_output_pair(sop), .aux_out(aux), .lockout(lock),
        .irq(irq));
    edmon_relay_model relay (.pclk(pclk), .presetn(presetn), .drive(sop),
        .delay(delay), .stuck(stuck), .split(split), .two_ch(two_ch),
        .fb(fb));
    always #25 pclk = ~pclk;
    // one apb transfer and an idle cycle, result left in rd and err
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // control write: cfg, run bit, optional reset pulse
    task automatic ctl(input logic [1:0] cfg, input logic r);
        apb(1'b1, EDMON_CTRL_OFF, {28'h0, r, 1'b1, cfg});
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic t_regs;
        apb(1'b0, EDMON_CTRL_OFF, 32'h0);
        chk("cfg", 32'h2, rd & 32'h3);
        apb(1'b0, EDMON_MASK_OFF, 32'h0);
        chk("mask", 32'h0, rd);
        apb(1'b0, 12'h010, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
    endtask
    task automatic t_refuse;
        two_ch <= 1'b0;
        stuck <= 1'b1;
        ctl(2'h1, 1'b0);
        gc <= 1'b1;
        ctl(2'h1, 1'b1);
        cyc(3);
        chk("sop", 32'h0, {30'h0, sop});
        apb(1'b0, EDMON_IRQS_OFF, 32'h0);
        chk("refused", 32'h2, rd & 32'h2);
        apb(1'b1, EDMON_MASK_OFF, 32'h2);
        cyc(1);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, EDMON_IRQS_OFF, 32'h2);
        cyc(1);
        chk("irq", 32'h0, {31'h0, irq});
        stuck <= 1'b0;
        cyc(4);
    endtask
    task automatic t_single;
        ctl(2'h1, 1'b1);
        cyc(3);
        chk("sop", 32'h3, {30'h0, sop});
        chk("aux", 32'h1, {31'h0, aux});
        cyc(10);
        chk("sop", 32'h3, {30'h0, sop});
        gc <= 1'b0;
        cyc(3);
        chk("aux", 32'h0, {31'h0, aux});
        cyc(WIN + 8);
        chk("lock", 32'h0, {31'h0, lock});
        gc <= 1'b1;
        ctl(2'h1, 1'b1);
        cyc(3);
        delay <= 8'(WIN + 10);
        gc <= 1'b0;
        cyc(WIN + 8);
        chk("lock", 32'h1, {31'h0, lock});
        chk("sop", 32'h0, {30'h0, sop});
        apb(1'b0, EDMON_IRQS_OFF, 32'h0);
        chk("irq_lock", 32'h1, rd & 32'h1);
        cyc(12);
        delay <= 8'h02;
        ctl(2'h1, 1'b1);
        cyc(2);
        chk("lock", 32'h0, {31'h0, lock});
    endtask
    task automatic t_dual;
        two_ch <= 1'b1;
        gc <= 1'b1;
        ctl(2'h2, 1'b1);
        cyc(3);
        chk("sop", 32'h3, {30'h0, sop});
        chk("aux", 32'h0, {31'h0, aux});
        split <= 1'b1;
        cyc(WIN - 6);
        split <= 1'b0;
        cyc(2);
        chk("lock", 32'h0, {31'h0, lock});
        split <= 1'b1;
        cyc(WIN + 5);
        chk("lock", 32'h1, {31'h0, lock});
        split <= 1'b0;
        gc <= 1'b0;
        cyc(5);
    endtask
    task automatic t_modes;
        apb(1'b1, EDMON_CTRL_OFF, 32'h7);
        apb(1'b0, EDMON_CTRL_OFF, 32'h0);
        chk("cfg", 32'h2, rd & 32'h3);
        stuck <= 1'b1;
        gc <= 1'b1;
        ctl(2'h0, 1'b0);
        ctl(2'h0, 1'b1);
        cyc(3);
        chk("sop", 32'h3, {30'h0, sop});
    endtask
    task automatic print_verdict;
        if (n_mismatch == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // hang guard, well beyond the few hundred cycles the tests take
    initial begin
        repeat (3000) @(posedge pclk);
        n_mismatch++;
        print_verdict;
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_refuse;
        t_single;
        t_dual;
        t_modes;
        print_verdict;
    end
endmodule // tb_top
